// [src/phy_status_id_pkg.sv]
// constants for the phy status and identifier register block
package phy_status_id_pkg;

  // ---------------------------------------------------------------
  // register addresses on the management port (5-bit)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_BASIC_STATUS   = 5'h01;
  localparam logic [4:0] ADDR_PHY_ID_HIGH    = 5'h02;
  localparam logic [4:0] ADDR_PHY_ID_LOW     = 5'h03;
  localparam logic [4:0] ADDR_IRQ_STATUS     = 5'h11;

  // ---------------------------------------------------------------
  // basic status field positions
  // ---------------------------------------------------------------
  localparam int         BIT_AUTONEG_ABLE    = 3;
  localparam int         BIT_LINK_UP         = 2;
  localparam int         BIT_LONG_TX         = 1;
  localparam int         BIT_EXT_CAPABLE     = 0;

  // ---------------------------------------------------------------
  // identifier layout and reset values (values are arbitrary)
  // ---------------------------------------------------------------
  localparam int         ID_HIGH_FIRST_BIT   = 3;
  localparam int         ID_LOW_FIRST_BIT    = 19;
  localparam int         ID_LOW_WIDTH        = 6;
  localparam int         ID_LOW_TOP          = 15;
  localparam logic [15:0] ID_HIGH_RESET      = 16'h5a3c;
  localparam logic [5:0]  ID_LOW_VENDOR      = 6'h15;
  localparam logic [15:0] ZERO_WORD          = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         CLK_KHZ             = 200000;
  localparam int         LONG_TX_MS          = 105;
  localparam int         LONG_TX_CYCLES      = LONG_TX_MS * CLK_KHZ;

endpackage

// [src/phy_status_id_regs.sv]
// status and identifier registers with latched link and long-transmit detection
//
// Notes on behaviour
// - status bit 3 always reads one: auto-negotiation capable.
// - status bit 2 reads one while a valid link is established, except on the first status read after reset.
// - a link failure clears bit 2 and holds it low until status read.
// - 10 Mb/s transmit over 105 ms is cut off and sets jabber bit.
// - jabber event with the jabber mask bit set raises the interrupt output.
// - jabber bit sticks until status read, interrupt status read, or reset.
// - no jabber detection while running at 100 Mb/s.
// - status bit 0 always reads one: extended registers present.
// - identifier bits 3..18 sit in register bits 15..0, reversed.
// - while legacy mode is set, writes to identifier register are ignored.
// - second identifier register carries identifier bits 19..24 in bits 15..10.
`timescale 1ns/10ps
module phy_status_id_regs
#(
  parameter int LONG_TX_LIMIT = phy_status_id_pkg::LONG_TX_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  input  wire logic        link_ok,
  input  wire logic        speed_100,
  input  wire logic        tx_active,
  input  wire logic        long_tx_irq_mask,
  input  wire logic        legacy_compat,
  output logic             tx_cutoff,
  output logic             mgmt_irq,
  output logic      [15:0] vendor_identifier
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        rd_status;
  logic        rd_irq_status;
  logic        wr_id_high;
  logic        long_tx_event;
  logic [31:0] tx_count_r;
  logic        cutoff_r;
  logic        link_latched_r;
  logic        link_latched_nxt;
  logic        long_tx_r;
  logic        long_tx_nxt;
  logic        irq_r;
  logic [15:0] id_high_r;
  logic [15:0] id_low_word;
  logic [15:0] status_word;
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;
  logic        rvalid_r;

  assign rd_status     = mgmt_rd && (mgmt_addr == phy_status_id_pkg::ADDR_BASIC_STATUS);
  assign rd_irq_status = mgmt_rd && (mgmt_addr == phy_status_id_pkg::ADDR_IRQ_STATUS);
  assign wr_id_high    = mgmt_wr && (mgmt_addr == phy_status_id_pkg::ADDR_PHY_ID_HIGH);

  // ---------------------------------------------------------------
  // long transmit timer
  // ---------------------------------------------------------------
  // counts only during 10 Mb/s transmit; the cut-off holds until transmit ends or speed_100 rises
  assign long_tx_event = tx_active && !speed_100 && !cutoff_r
                         && (tx_count_r == 32'(LONG_TX_LIMIT - 1));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_count_r <= 32'h0000_0000;
    end
    else if (!tx_active || speed_100)
    begin
      tx_count_r <= 32'h0000_0000;
    end
    else if (!cutoff_r)
    begin
      tx_count_r <= tx_count_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cutoff_r <= 1'b0;
    end
    else if (!tx_active || speed_100)
    begin
      cutoff_r <= 1'b0;
    end
    else if (long_tx_event)
    begin
      cutoff_r <= 1'b1;
    end
  end

  assign tx_cutoff = cutoff_r;

  // ---------------------------------------------------------------
  // latched link and jabber flags
  // ---------------------------------------------------------------
  always_comb
  begin
    if (rd_status)
    begin
      link_latched_nxt = link_ok;
    end
    else
    begin
      link_latched_nxt = link_latched_r && link_ok;
    end
  end

  // a new event in the clearing cycle wins over the clear
  assign long_tx_nxt = long_tx_event || (long_tx_r && !rd_status && !rd_irq_status);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_latched_r <= 1'b0;
      long_tx_r      <= 1'b0;
    end
    else
    begin
      link_latched_r <= link_latched_nxt;
      long_tx_r      <= long_tx_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= long_tx_nxt && long_tx_irq_mask;
    end
  end

  assign mgmt_irq = irq_r;

  // ---------------------------------------------------------------
  // identifier registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      id_high_r <= phy_status_id_pkg::ID_HIGH_RESET;
    end
    else if (wr_id_high && !legacy_compat)
    begin
      id_high_r <= mgmt_wdata;
    end
  end

  // vendor_identifier[i] carries identifier bit (3 + i); register bit 15 holds bit 3
  generate
    for (genvar i = 0; i < 16; i++)
    begin : g_id_high
      assign vendor_identifier[i] = id_high_r[15 - i];
    end
    for (genvar j = 0; j < 16; j++)
    begin : g_id_low
      if (j > phy_status_id_pkg::ID_LOW_TOP - phy_status_id_pkg::ID_LOW_WIDTH)
      begin : g_vendor
        // ID_LOW_VENDOR[k] is identifier bit (19 + k), placed at register bit 15 - k
        assign id_low_word[j] = phy_status_id_pkg::ID_LOW_VENDOR[15 - j];
      end
      else
      begin : g_zero
        assign id_low_word[j] = 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb
  begin
    status_word = phy_status_id_pkg::ZERO_WORD;
    status_word[phy_status_id_pkg::BIT_AUTONEG_ABLE] = 1'b1;
    status_word[phy_status_id_pkg::BIT_LINK_UP]      = link_latched_r;
    status_word[phy_status_id_pkg::BIT_LONG_TX]      = long_tx_r;
    status_word[phy_status_id_pkg::BIT_EXT_CAPABLE]  = 1'b1;
  end

  always_comb
  begin
    if (mgmt_addr == phy_status_id_pkg::ADDR_BASIC_STATUS)
    begin
      rdata_nxt = status_word;
    end
    else if (mgmt_addr == phy_status_id_pkg::ADDR_PHY_ID_HIGH)
    begin
      rdata_nxt = id_high_r;
    end
    else if (mgmt_addr == phy_status_id_pkg::ADDR_PHY_ID_LOW)
    begin
      rdata_nxt = id_low_word;
    end
    else
    begin
      rdata_nxt = phy_status_id_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_r  <= phy_status_id_pkg::ZERO_WORD;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= mgmt_rd;
      if (mgmt_rd)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign mgmt_rdata  = rdata_r;
  assign mgmt_rvalid = rvalid_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_status_fixed_ones: assert property (@(posedge clk) disable iff (!resetn)
    rd_status |=> (mgmt_rdata[3] && mgmt_rdata[0] && mgmt_rvalid))
    else $error("fixed status bits not one");

  chk_ext_capable: assert property (@(posedge clk) disable iff (!resetn)
    (mgmt_rvalid && $past(mgmt_addr) == phy_status_id_pkg::ADDR_BASIC_STATUS) |-> mgmt_rdata[0])
    else $error("extended capability bit not one");

  chk_link_latch_low: assert property (@(posedge clk) disable iff (!resetn)
    (!link_ok && !rd_status) ##1 (link_ok && !rd_status)[*3] |=> !link_latched_r)
    else $error("link bit recovered without a status read");

  chk_link_live_reload: assert property (@(posedge clk) disable iff (!resetn)
    rd_status |=> (link_latched_r == $past(link_ok)))
    else $error("link bit did not follow live link after read");

  chk_link_read_value: assert property (@(posedge clk) disable iff (!resetn)
    (link_ok && link_latched_r && rd_status) |=> mgmt_rdata[2])
    else $error("link up not reported");

  chk_jabber_sticky: assert property (@(posedge clk) disable iff (!resetn)
    (long_tx_r && !rd_status && !rd_irq_status) |=> long_tx_r)
    else $error("jabber bit dropped without a clearing read");

  chk_jabber_clear: assert property (@(posedge clk) disable iff (!resetn)
    (rd_irq_status && !long_tx_event) |=> !long_tx_r)
    else $error("jabber bit not cleared by interrupt status read");

  chk_jabber_sets: assert property (@(posedge clk) disable iff (!resetn)
    long_tx_event |=> (long_tx_r && tx_cutoff))
    else $error("long transmit not flagged and cut off");

  chk_no_fast_jabber: assert property (@(posedge clk) disable iff (!resetn)
    speed_100 |=> (!tx_cutoff && tx_count_r == 32'h0000_0000))
    else $error("jabber timing active at 100 Mb/s");

  chk_irq_follows: assert property (@(posedge clk) disable iff (!resetn)
    (long_tx_event && long_tx_irq_mask) |=> mgmt_irq)
    else $error("masked-in jabber did not raise interrupt");

  chk_id_locked: assert property (@(posedge clk) disable iff (!resetn)
    (wr_id_high && legacy_compat) |=> $stable(id_high_r))
    else $error("identifier written in legacy mode");

  chk_id_reversed: assert property (@(posedge clk) disable iff (!resetn)
    (wr_id_high && !legacy_compat) |=> (vendor_identifier[0] == $past(mgmt_wdata[15])))
    else $error("identifier bit order wrong");

  chk_id_low_zero: assert property (@(posedge clk) disable iff (!resetn)
    (mgmt_rd && mgmt_addr == phy_status_id_pkg::ADDR_PHY_ID_LOW) |=> (mgmt_rdata[9:0] == 10'h000))
    else $error("second identifier low bits not zero");

endmodule

// [verification/mgmt_station.sv]
// management station model driving the deframed register port
`timescale 1ns/10ps
module mgmt_station
(
  input  wire logic        clk,
  output logic      [4:0]  mgmt_addr,
  output logic             mgmt_rd,
  output logic             mgmt_wr,
  output logic      [15:0] mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid
);
  initial
  begin
    mgmt_addr  = 5'h00;
    mgmt_rd    = 1'b0;
    mgmt_wr    = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // one-cycle read strobe; word taken only with the answer pulse
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    @(negedge clk);
    mgmt_rd   = 1'b0;
    mgmt_addr = ~a;
    d         = mgmt_rvalid ? mgmt_rdata : 16'hxxxx;
  endtask

  // released lines show the inverse so stale values never match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_addr  = a;
    mgmt_wdata = d;
    mgmt_wr    = 1'b1;
    @(negedge clk);
    mgmt_wr    = 1'b0;
    mgmt_addr  = ~a;
    mgmt_wdata = ~d;
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the status and identifier register block
`timescale 1ns/10ps
module tb_top;
  localparam int LIM = 20;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  mgmt_addr;
  logic        mgmt_rd;
  logic        mgmt_wr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic        mgmt_rvalid;
  logic        link_ok = 1'b1;
  logic        speed_100 = 1'b0;
  logic        tx_active = 1'b0;
  logic        long_tx_irq_mask = 1'b1;
  logic        legacy_compat = 1'b0;
  logic        tx_cutoff;
  logic        mgmt_irq;
  logic [15:0] vendor_identifier;
  logic [15:0] d;
  int          miscompares = 0;
  int          n_checks = 0;

  always #2.5 clk = ~clk;

  phy_status_id_regs #(.LONG_TX_LIMIT(LIM)) i_phy_status_id_regs (
    .clk               (clk),
    .resetn            (resetn),
    .mgmt_addr         (mgmt_addr),
    .mgmt_rd           (mgmt_rd),
    .mgmt_wr           (mgmt_wr),
    .mgmt_wdata        (mgmt_wdata),
    .mgmt_rdata        (mgmt_rdata),
    .mgmt_rvalid       (mgmt_rvalid),
    .link_ok           (link_ok),
    .speed_100         (speed_100),
    .tx_active         (tx_active),
    .long_tx_irq_mask  (long_tx_irq_mask),
    .legacy_compat     (legacy_compat),
    .tx_cutoff         (tx_cutoff),
    .mgmt_irq          (mgmt_irq),
    .vendor_identifier (vendor_identifier)
  );
  mgmt_station i_mgmt_station (
    .clk         (clk),
    .mgmt_addr   (mgmt_addr),
    .mgmt_rd     (mgmt_rd),
    .mgmt_wr     (mgmt_wr),
    .mgmt_wdata  (mgmt_wdata),
    .mgmt_rdata  (mgmt_rdata),
    .mgmt_rvalid (mgmt_rvalid)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] rev16(input logic [15:0] x);
    for (int i = 0; i < 16; i++)
      rev16[i] = x[15-i];
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    i_mgmt_station.rd(a, d);
    chk("rdata", exp, d);
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_link();
    rdchk(5'h01, 16'h0009);
    rdchk(5'h01, 16'h000d);
    @(negedge clk);
    link_ok = 1'b0;
    @(negedge clk);
    link_ok = 1'b1;
    repeat (3) @(negedge clk);
    rdchk(5'h01, 16'h0009);
    rdchk(5'h01, 16'h000d);
  endtask

  task automatic t_jabber(input logic mask, input logic [4:0] clr_addr, input logic [15:0] clr_exp);
    int n;
    long_tx_irq_mask = mask;
    @(negedge clk);
    tx_active = 1'b1;
    n = 0;
    while (tx_cutoff !== 1'b1 && n < 2 * LIM)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2 * LIM)
    begin
      miscompares++;
      end_sim();
    end
    chk("cut_time", 16'(LIM), 16'(n));
    chk("irq", {15'h0, mask}, {15'h0, mgmt_irq});
    tx_active = 1'b0;
    @(negedge clk);
    chk("cutoff", 16'h0000, {15'h0, tx_cutoff});
    repeat (4) @(negedge clk);
    rdchk(clr_addr, clr_exp);
    rdchk(5'h01, 16'h000d);
    chk("irq", 16'h0000, {15'h0, mgmt_irq});
  endtask

  task automatic t_fast();
    speed_100 = 1'b1;
    tx_active = 1'b1;
    repeat (2 * LIM) @(negedge clk);
    chk("cutoff", 16'h0000, {15'h0, tx_cutoff});
    rdchk(5'h01, 16'h000d);
    tx_active = 1'b0;
    speed_100 = 1'b0;
  endtask

  task automatic t_ident();
    chk("vid", rev16(phy_status_id_pkg::ID_HIGH_RESET), vendor_identifier);
    rdchk(5'h02, phy_status_id_pkg::ID_HIGH_RESET);
    legacy_compat = 1'b1;
    i_mgmt_station.wr(5'h02, 16'h1234);
    rdchk(5'h02, phy_status_id_pkg::ID_HIGH_RESET);
    legacy_compat = 1'b0;
    i_mgmt_station.wr(5'h02, 16'h1234);
    rdchk(5'h02, 16'h1234);
    chk("vid", rev16(16'h1234), vendor_identifier);
    rdchk(5'h03, rev16({10'h000, phy_status_id_pkg::ID_LOW_VENDOR}));
    rdchk(5'h05, 16'h0000);
  endtask

  // mid-run reset: jabber flag, interrupt, link flag and identifier return to reset values
  task automatic t_reset();
    long_tx_irq_mask = 1'b1;
    tx_active = 1'b1;
    repeat (LIM + 1) @(negedge clk);
    chk("irq", 16'h0001, {15'h0, mgmt_irq});
    tx_active = 1'b0;
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    chk("irq", 16'h0000, {15'h0, mgmt_irq});
    chk("vid", rev16(phy_status_id_pkg::ID_HIGH_RESET), vendor_identifier);
    rdchk(5'h01, 16'h0009);
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    t_link();
    t_jabber(1'b1, 5'h01, 16'h000f);
    t_jabber(1'b0, 5'h11, 16'h0000);
    t_fast();
    t_ident();
    t_reset();
    end_sim();
  end
endmodule
